/* File: design/rct_defines.svh */
/*
 * Register offsets, field positions, reset values and rate figures of the
 * clock-out, countdown timer and test block. Assumes the including file
 * wants these names globally and declares nothing of its own with them.
 */
`ifndef RCT_DEFINES_SVH
`define RCT_DEFINES_SVH

// ****************************************************************
// Register word addresses
// ****************************************************************
`define RCT_ADDR_CLOCK_OUTPUT_PIN 4'hD
`define RCT_ADDR_TCTRL 4'hE
`define RCT_ADDR_TCOUNT 4'hF

// ****************************************************************
// Field positions
// ****************************************************************
`define RCT_BIT_ENABLE 7
`define RCT_SEL_HI 1
`define RCT_SEL_LO 0

// ****************************************************************
// Reset values
// ****************************************************************
`define RCT_RST_CLOCK_OUTPUT_PIN 8'h80
`define RCT_RST_TCTRL 8'h03
`define RCT_RST_TCOUNT 8'h00

// ****************************************************************
// Rates
// ****************************************************************
`define RCT_SYS_HZ 20000000
`define RCT_BASE_HZ 65536
`define RCT_SEL_FAST 2'h0
`define RCT_SEL_MID 2'h1
`define RCT_SEL_SLOW 2'h2
`define RCT_SEL_MIN 2'h3
`define RCT_PRE_HALF 6'h1F
`define RCT_SEC_PER_MIN 6'h3B

// ****************************************************************
// Divider taps, masks and synchroniser reset level
// ****************************************************************
`define RCT_TAP_FAST 0
`define RCT_TAP_MID 5
`define RCT_TAP_SLOW 10
`define RCT_TAP_MIN 15
`define RCT_DIV_4096 4'hF
`define RCT_DIV_64 10'h3FF
`define RCT_CFG_MASK 8'h83
`define RCT_RST_SYNC 2'h3

`endif

/* File: design/rct_pkg.sv */
/*
 * Types shared by the clock-out and timer block. Assumes the defines header
 * is compiled alongside for every number.
 */
package rct_pkg;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } rct_reg_wr_t;

    typedef struct packed {
        logic t4096;
        logic t64;
        logic t1;
        logic t60;
    } rct_ticks_t;

    typedef enum logic [2:0] {
        OVR_IDLE = 3'b001,
        OVR_SEEK = 3'b010,
        OVR_ON = 3'b100
    } rct_ovr_state_t;

    // ****************************************************************
    // Module state
    // ****************************************************************
    typedef struct packed {
        logic [5:0] pre;
        logic sec;
    } rct_pre_state_t;

    typedef struct packed {
        logic [7:0] count;
        logic flag;
    } rct_tmr_state_t;

endpackage : rct_pkg

/* File: design/rct_prescale.sv */
/*
 * Six-stage binary prescaler turning the 64 Hz tick into the seconds tick.
 * Assumes the tick input is a one-cycle pulse on the system clock.
 */
`include "rct_defines.svh"

module rct_prescale
    import rct_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic tick_in,
    input wire logic stop,
    // Result
    output logic sec_tick
);

    rct_pre_state_t st;
    rct_pre_state_t next_st;

    // The seconds tick fires when the chain passes the half point, so a
    // chain cleared by stop needs 32 edges first and 64 thereafter.
    always_comb begin
        next_st = st;
        next_st.sec = 1'b0;
        if (stop) begin
            next_st.pre = '0;
        end else if (tick_in) begin
            next_st.pre = st.pre + 6'h01;
            next_st.sec = (st.pre == `RCT_PRE_HALF);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sec_tick = st.sec;

endmodule : rct_prescale

/* File: design/rct_timer.sv */
/*
 * Eight-bit binary countdown timer with reload. Assumes all ticks are
 * one-cycle pulses and that the select code is stable between writes.
 */
`include "rct_defines.svh"

module rct_timer
    import rct_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Ticks and control
    input rct_ticks_t ticks,
    input wire logic run,
    input wire logic [1:0] sel,
    input wire logic load,
    input wire logic [7:0] reload,
    // Results
    output logic [7:0] count,
    output logic flag
);

    rct_tmr_state_t st;
    rct_tmr_state_t next_st;
    logic tick;

    always_comb begin
        case (sel)
            `RCT_SEL_FAST: tick = ticks.t4096;
            `RCT_SEL_MID: tick = ticks.t64;
            `RCT_SEL_SLOW: tick = ticks.t1;
            default: tick = ticks.t60;
        endcase
    end

    // A write of n restarts the count so that the first period is n ticks.
    always_comb begin
        next_st = st;
        next_st.flag = 1'b0;
        if (load) begin
            next_st.count = reload;
        end else if (run && tick) begin
            if (st.count == 8'h01 || st.count == 8'h00) begin
                next_st.flag = 1'b1;
                next_st.count = reload;
            end else begin
                next_st.count = st.count - 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;
    assign flag = st.flag;

endmodule : rct_timer

/* File: design/rct_top.sv */
/*
 * Clock output, countdown timer, external-clock test mode and power-on
 * reset override of a real-time clock. Assumes a serial bus engine on the
 * same clock delivers register writes and addresses, and that the test and
 * stop bits and the override-allow bit come from its control register.
 */
`include "rct_defines.svh"

module rct_top
    import rct_pkg::*;
#(
    parameter int OVR_STEPS = 4,
    // Pin states {data, clock} to be seen in order; values are assumed.
    parameter logic [OVR_STEPS-1:0][1:0] OVR_SEQ = {2'b10, 2'b00, 2'b01, 2'b11}
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // Register access from the serial engine
    input rct_reg_wr_t REG_WR,
    output logic [7:0] REG_RDATA,
    // Control bits from control/status register 1
    input wire logic EXT_TEST,
    input wire logic PRE_STOP,
    input wire logic OVR_ALLOW,
    // Power-on reset pending, asynchronous
    input wire logic POR_PENDING,
    // Serial bus pins seen for the override sequence
    input wire logic SDA_IN,
    input wire logic SCL_IN,
    // Clock output pin, three-signal form
    input wire logic CLOCK_OUTPUT_PIN_I,
    output logic CLOCK_OUTPUT_PIN_O,
    output logic CLOCK_OUTPUT_PIN_OE,
    // Results
    output logic SEC_TICK,
    output logic TIMER_FLAG,
    output logic CORE_RESET
);

    localparam logic [25:0] ACC_MOD = 26'(`RCT_SYS_HZ);
    localparam logic [25:0] ACC_STEP = 26'(`RCT_BASE_HZ);
    localparam int IW = $clog2(OVR_STEPS + 1);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [25:0] acc;
        logic base_en;
        logic [15:0] base;
        logic [5:0] sec_cnt;
        logic [1:0] por_sync;
        logic [1:0] sda_sync;
        logic [1:0] scl_sync;
        logic [1:0] ck_sync;
        logic ck_last;
        rct_ovr_state_t ovr;
        logic [IW-1:0] idx;
        logic [7:0] clk_cfg;
        logic [7:0] tmr_cfg;
        logic [7:0] tmr_n;
        logic [7:0] rdata;
        logic pin;
    } rct_top_state_t;

    rct_top_state_t st;
    rct_top_state_t next_st;
    rct_ticks_t ticks;
    logic core_rst;
    logic sec_tick;
    logic [7:0] tmr_count;
    logic tmr_flag;
    logic test_mode;
    logic ext_rise;
    logic [1:0] pins;
    logic seq_hit;
    logic wr_clock_output_pin;
    logic wr_tctrl;
    logic wr_tcount;
    logic [7:0] tmr_reload;
    logic [1:0] clk_sel;
    logic [1:0] tmr_sel;
    logic tmr_run;
    logic [IW-2:0] seq_pos;

    // ****************************************************************
    // Reset release
    // ****************************************************************

    // Logic behind the oscillator waits for power-on reset unless the
    // override has been entered; the override detector itself only obeys
    // the system reset, otherwise it could never leave reset.
    // override releases reset
    assign core_rst = RESET | (st.por_sync[1] & (st.ovr != OVR_ON));
    assign CORE_RESET = core_rst;

    // ****************************************************************
    // Write decode
    // ****************************************************************

    // Writes are taken only while the core runs, since a held core would
    // drop them anyway; the chain hits at most one register per cycle.
    always_comb begin
        wr_clock_output_pin = 1'b0;
        wr_tctrl = 1'b0;
        wr_tcount = 1'b0;
        if (REG_WR.wr && !core_rst) begin
            if (REG_WR.addr == `RCT_ADDR_CLOCK_OUTPUT_PIN) begin
                wr_clock_output_pin = 1'b1;
            end else if (REG_WR.addr == `RCT_ADDR_TCTRL) begin
                wr_tctrl = 1'b1;
            end else if (REG_WR.addr == `RCT_ADDR_TCOUNT) begin
                wr_tcount = 1'b1;
            end
        end
    end

    // A fresh count goes straight into the timer so the first period after
    // a write is the full n; otherwise the timer reloads the held value.
    assign tmr_reload = wr_tcount ? REG_WR.wdata : st.tmr_n;

    // Configuration fields used by the rate and timer logic.
    assign clk_sel = st.clk_cfg[`RCT_SEL_HI:`RCT_SEL_LO];
    assign tmr_sel = st.tmr_cfg[`RCT_SEL_HI:`RCT_SEL_LO];
    assign tmr_run = st.tmr_cfg[`RCT_BIT_ENABLE];

    // ****************************************************************
    // Tick generation
    // ****************************************************************

    assign test_mode = EXT_TEST;
    assign ext_rise = st.ck_sync[1] & ~st.ck_last;
    assign pins = {st.sda_sync[1], st.scl_sync[1]};
    assign seq_pos = st.idx[IW-2:0];
    assign seq_hit = (pins == OVR_SEQ[seq_pos]);

    // Internal rates fall out of one 16-bit counter that steps at 65536 Hz.
    // In test mode the pin edges take the place of the internal 64 Hz.
    // The seconds tick comes back from the prescaler, so in test mode the
    // 1 Hz and 1/60 Hz timer sources follow the pin as well.
    always_comb begin
        ticks.t4096 = st.base_en && (st.base[3:0] == `RCT_DIV_4096);
        if (test_mode) begin
            ticks.t64 = ext_rise;
        end else begin
            ticks.t64 = st.base_en && (st.base[9:0] == `RCT_DIV_64);
        end
        ticks.t1 = sec_tick;
        ticks.t60 = sec_tick && (st.sec_cnt == `RCT_SEC_PER_MIN);
    end

    // Entering test mode does not clear the chain; a host uses the stop bit
    // to bring it to a known state first.
    // no sync on entry
    rct_prescale u_pre (
        .clk(SYS_CLK),
        .rst(core_rst),
        .tick_in(ticks.t64),
        .stop(PRE_STOP),
        .sec_tick(sec_tick)
    );

    // The timer takes its rate, run bit and reload from the registers here;
    // a write to the count register restarts it at once.
    rct_timer u_tmr (
        .clk(SYS_CLK),
        .rst(core_rst),
        .ticks(ticks),
        .run(tmr_run),
        .sel(tmr_sel),
        .load(wr_tcount),
        .reload(tmr_reload),
        .count(tmr_count),
        .flag(tmr_flag)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************

    // One process computes all next values; the fractional accumulator keeps
    // the 65536 Hz step exact on average, with one system cycle of jitter.
    always_comb begin
        next_st = st;
        next_st.por_sync = {st.por_sync[0], POR_PENDING};
        next_st.sda_sync = {st.sda_sync[0], SDA_IN};
        next_st.scl_sync = {st.scl_sync[0], SCL_IN};
        next_st.ck_sync = {st.ck_sync[0], CLOCK_OUTPUT_PIN_I};
        next_st.ck_last = st.ck_sync[1];
        if (st.acc + ACC_STEP >= ACC_MOD) begin
            next_st.acc = st.acc + ACC_STEP - ACC_MOD;
            next_st.base_en = 1'b1;
        end else begin
            next_st.acc = st.acc + ACC_STEP;
            next_st.base_en = 1'b0;
        end
        if (st.base_en) begin
            next_st.base = st.base + 16'h0001;
        end
        if (sec_tick) begin
            next_st.sec_cnt = (st.sec_cnt == `RCT_SEC_PER_MIN) ? 6'h00 : st.sec_cnt + 6'h01;
        end
        case (clk_sel)
            `RCT_SEL_FAST: next_st.pin = st.base[`RCT_TAP_FAST];
            `RCT_SEL_MID: next_st.pin = st.base[`RCT_TAP_MID];
            `RCT_SEL_SLOW: next_st.pin = st.base[`RCT_TAP_SLOW];
            default: next_st.pin = st.base[`RCT_TAP_MIN];
        endcase
        // Register writes; unused bits are kept at zero so they read back 0.
        if (wr_clock_output_pin) begin
            next_st.clk_cfg = REG_WR.wdata & `RCT_CFG_MASK;
        end else if (wr_tctrl) begin
            next_st.tmr_cfg = REG_WR.wdata & `RCT_CFG_MASK;
        end else if (wr_tcount) begin
            next_st.tmr_n = REG_WR.wdata;
        end
        // Read data is registered from the presented address.
        if (REG_WR.addr == `RCT_ADDR_CLOCK_OUTPUT_PIN) begin
            next_st.rdata = st.clk_cfg;
        end else if (REG_WR.addr == `RCT_ADDR_TCTRL) begin
            next_st.rdata = st.tmr_cfg;
        end else if (REG_WR.addr == `RCT_ADDR_TCOUNT) begin
            next_st.rdata = tmr_count;
        end else begin
            next_st.rdata = 8'h00;
        end
        // The entry order of the bus pins is an assumption held in OVR_SEQ:
        // with the defaults, {data, clock} must read 11, 01, 00 and 10 in turn.
        // Holding a state is allowed, since the host toggles slowly against
        // this clock; any state that is neither the current nor the next step
        // starts the search over. Only the system reset clears the detector,
        // so it still acts while the power-on reset holds the rest.
        // parameterised pin sequence
        case (st.ovr)
            OVR_IDLE: begin
                next_st.idx = '0;
                if (OVR_ALLOW) begin
                    next_st.ovr = OVR_SEEK;
                end
            end
            OVR_SEEK: begin
                if (!OVR_ALLOW) begin
                    next_st.ovr = OVR_IDLE;
                end else if (seq_hit && st.idx == IW'(OVR_STEPS - 1)) begin
                    next_st.ovr = OVR_ON;
                end else if (seq_hit) begin
                    next_st.idx = st.idx + 1'b1;
                end else if (st.idx != '0 && pins != OVR_SEQ[seq_pos - 1'b1]) begin
                    next_st.idx = '0;
                end
            end
            OVR_ON: begin
                if (!OVR_ALLOW) begin
                    next_st.ovr = OVR_IDLE;
                end
            end
            default: next_st.ovr = OVR_IDLE;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Configuration follows the core reset so a pending power-on reset
    // keeps it at defaults; synchronisers and the detector do not.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            st <= '0;
            // The pending flag is assumed until the pin is seen low, so the
            // core stays held through the synchroniser delay after reset.
            st.por_sync <= `RCT_RST_SYNC;
            st.ovr <= OVR_IDLE;
            st.clk_cfg <= `RCT_RST_CLOCK_OUTPUT_PIN;
            st.tmr_cfg <= `RCT_RST_TCTRL;
            st.tmr_n <= `RCT_RST_TCOUNT;
        end else if (core_rst) begin
            st <= next_st;
            st.clk_cfg <= `RCT_RST_CLOCK_OUTPUT_PIN;
            st.tmr_cfg <= `RCT_RST_TCTRL;
            st.tmr_n <= `RCT_RST_TCOUNT;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // The pin floats in test mode and in reset, so an external test clock
    // never fights the driver.
    // enable drives or floats
    assign CLOCK_OUTPUT_PIN_OE = st.clk_cfg[`RCT_BIT_ENABLE] & ~test_mode & ~core_rst;
    assign CLOCK_OUTPUT_PIN_O = st.pin;
    assign REG_RDATA = st.rdata;
    assign SEC_TICK = sec_tick;
    assign TIMER_FLAG = tmr_flag;

endmodule : rct_top

/* File: dv/rct_partner.sv */
/*
 * Far side model: the host's bus pins and the external test clock.
 * Assumes the bench calls its tasks from one process only.
 */
module rct_partner
    import rct_pkg::*;
#(
    parameter logic [3:0][1:0] OVR_SEQ = {2'b10, 2'b00, 2'b01, 2'b11}
) (
    // Clock
    input wire logic clk,
    // Pins
    output logic sda,
    output logic scl,
    output logic external_clock_test_mode
);
    // Bus pins idle high by pull-up; the test clock rests low between bursts.
    initial begin
        sda = 1'b1;
        scl = 1'b1;
        external_clock_test_mode = 1'b0;
    end

    // test clock pulses
    // Each pulse is 400 ns high with a 1050 ns period, above the minimums.
    task automatic pulses(input int n);
        repeat (n) begin
            @(negedge clk);
            external_clock_test_mode = 1'b1;
            repeat (8) @(negedge clk);
            external_clock_test_mode = 1'b0;
            repeat (12) @(negedge clk);
        end
    endtask : pulses

    // override entry walk
    // The pins pass through the assumed entry order, then idle high.
    task automatic ovr_walk();
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            {sda, scl} = OVR_SEQ[i];
            repeat (4) @(negedge clk);
        end
        {sda, scl} = 2'b11;
    endtask : ovr_walk
endmodule : rct_partner

/* File: dv/rct_top_props.sv */
/*
 * Port checker for the clock-out and timer block.
 * Assumes it is bound to the top module, one clock, reset high.
 */
module rct_top_props
    import rct_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // Observed ports
    input rct_reg_wr_t REG_WR,
    input wire logic [7:0] REG_RDATA,
    input wire logic EXT_TEST,
    input wire logic PRE_STOP,
    input wire logic CLOCK_OUTPUT_PIN_OE,
    input wire logic SEC_TICK,
    input wire logic TIMER_FLAG,
    input wire logic CORE_RESET
);
    // ********
    // Rules
    // ********
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    logic run;

    // The run bit is shadowed here, since the ports do not show it.
    always_ff @(posedge SYS_CLK) begin
        if (RESET || CORE_RESET) begin
            run <= 1'b0;
        end else if (REG_WR.wr && !CORE_RESET && REG_WR.addr == 4'hE) begin
            run <= REG_WR.wdata[7];
        end
    end

    sequence s_cfg_wr;
        REG_WR.wr && REG_WR.addr == 4'hD && !CORE_RESET;
    endsequence
    sequence s_cfg_rd;
        !REG_WR.wr && REG_WR.addr == 4'hD;
    endsequence

    a_cfg_readback: assert property (s_cfg_wr ##1 s_cfg_rd |=>
        REG_RDATA == ($past(REG_WR.wdata, 2) & 8'h83)) else $error("config readback wrong");
    a_test_input: assert property (EXT_TEST |-> !CLOCK_OUTPUT_PIN_OE)
        else $error("pin driven in test mode");
    a_core_quiet: assert property (CORE_RESET |-> !CLOCK_OUTPUT_PIN_OE)
        else $error("pin driven in reset");
    a_unmapped_zero: assert property (REG_WR.addr < 4'hD |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_gaps: assert property (REG_WR.addr == 4'hE |=> REG_RDATA[6:2] == 5'h00)
        else $error("unused control bits set");
    a_sec_pulse: assert property (SEC_TICK |=> !SEC_TICK)
        else $error("seconds tick too long");
    a_flag_pulse: assert property (TIMER_FLAG |=> !TIMER_FLAG)
        else $error("timer flag too long");
    a_stop_hold: assert property (PRE_STOP [*3] |-> !SEC_TICK)
        else $error("tick while stopped");
    a_halt_quiet: assert property (!run [*3] |-> !TIMER_FLAG)
        else $error("flag while halted");
endmodule : rct_top_props

bind rct_top rct_top_props u_rct_top_props (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .REG_WR(REG_WR), .REG_RDATA(REG_RDATA), .EXT_TEST(EXT_TEST), .PRE_STOP(PRE_STOP),
    .CLOCK_OUTPUT_PIN_OE(CLOCK_OUTPUT_PIN_OE), .SEC_TICK(SEC_TICK), .TIMER_FLAG(TIMER_FLAG),
    .CORE_RESET(CORE_RESET));

/* File: dv/tb_rct_top.sv */
/*
 * Self-checking bench for the clock-out and timer block.
 * Assumes the checker is bound in and the partner drives the pins.
 */
module tb_rct_top
    import rct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst = 1'b1;
    rct_reg_wr_t reg_wr = '0;
    logic ext_test = 1'b0;
    logic pre_stop = 1'b0;
    logic ovr_allow = 1'b0;
    logic por_pending = 1'b0;
    logic [7:0] rdata, rd, v, h;
    logic sda, scl, external_clock_test_mode, pin, ck_o, ck_oe, sec_tick, tmr_flag, core_rst;
    int err_total = 0;
    int checked = 0;
    int seed = 19;
    int secs = 0;
    int edges = 0;
    int n;

    rct_top u_rct_top (.SYS_CLK(clk), .RESET(rst), .REG_WR(reg_wr), .REG_RDATA(rdata),
        .EXT_TEST(ext_test), .PRE_STOP(pre_stop), .OVR_ALLOW(ovr_allow),
        .POR_PENDING(por_pending), .SDA_IN(sda), .SCL_IN(scl), .CLOCK_OUTPUT_PIN_I(pin),
        .CLOCK_OUTPUT_PIN_O(ck_o), .CLOCK_OUTPUT_PIN_OE(ck_oe), .SEC_TICK(sec_tick),
        .TIMER_FLAG(tmr_flag), .CORE_RESET(core_rst));
    rct_partner u_rct_partner (.clk(clk), .sda(sda), .scl(scl), .external_clock_test_mode(external_clock_test_mode));

    // The pin carries the design's value while enabled, else the test clock.
    assign pin = ck_oe ? ck_o : external_clock_test_mode;

    // The clock runs at 20 MHz.
    initial begin
        forever #25 clk = ~clk;
    end

    // Seconds ticks and clock-out edges are counted for the main sequence.
    always @(posedge clk) begin
        if (sec_tick === 1'b1) begin
            secs++;
        end
    end
    always @(posedge ck_o) begin
        edges++;
    end

    function automatic int out_hz(input int c);
        return (c == 0) ? 32768 : (c == 1) ? 1024 : (c == 2) ? 32 : 1;
    endfunction : out_hz

    task automatic finish_test();
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp8

    task automatic cmp_rng(input int got, input int lo, input int hi, input string what);
        checked++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("Error %0t %s count %0d", $time, what, got);
        end
    endtask : cmp_rng

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = '{wr: 1'b1, addr: a, wdata: d};
        @(negedge clk);
        reg_wr.wr = 1'b0;
    endtask : wr

    // reads outpace ticks
    // Read data is registered, so it is taken one full cycle after the address.
    task automatic rd_reg(input logic [3:0] a);
        @(negedge clk);
        reg_wr.addr = a;
        @(negedge clk);
        rd = rdata;
    endtask : rd_reg

    task automatic wait_flag(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
            if (cnt > 12000) begin
                $display("Error %0t wait for flag timed out", $time);
                err_total++;
                finish_test();
            end
        end while (tmr_flag !== 1'b1);
    endtask : wait_flag

    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        rd_reg(4'hD);
        cmp8(rd, 8'h80, "clock_output_pin reset");
        rd_reg(4'hE);
        cmp8(rd, 8'h03, "control reset");
        for (int i = 0; i < 13; i++) begin
            rd_reg(4'(i));
            cmp8(rd, 8'h00, "unmapped");
        end
        // Every rate code, with random junk in the unimplemented bits.
        for (int c = 0; c < 4; c++) begin
            v = 8'($random(seed)) & 8'h7C | 8'h80 | 8'(c);
            wr(4'hD, v);
            rd_reg(4'hD);
            cmp8(rd, v & 8'h83, "clock_output_pin readback");
            cmp8(8'(ck_oe), 8'h01, "pin enabled");
            edges = 0;
            repeat (12000) @(negedge clk);
            n = 12000 / 20 * out_hz(c) / 1000000;
            cmp_rng(edges, n - 1, n + 1, "clock_output_pin edges");
        end
        wr(4'hD, 8'h03);
        cmp8(8'(ck_oe), 8'h00, "pin released");
        v = 8'($random(seed));
        wr(4'hF, v);
        rd_reg(4'hF);
        cmp8(rd, v, "count load");
        // A binary step from 0x10 gives 0x0F, where a decimal counter gives 0x09.
        wr(4'hF, 8'h10);
        wr(4'hE, 8'h80);
        n = 0;
        do begin
            rd_reg(4'hF);
            n++;
        end while (rd === 8'h10 && n < 3000);
        cmp8(rd, 8'h0F, "binary step");
        wr(4'hE, 8'h00);
        rd_reg(4'hF);
        h = rd;
        repeat (10000) @(negedge clk);
        rd_reg(4'hF);
        cmp8(rd, h, "halted count");
        wr(4'hF, 8'h02);
        wr(4'hE, 8'h80);
        wait_flag(n);
        rd_reg(4'hF);
        cmp8(rd, 8'h02, "reload");
        wait_flag(n);
        cmp_rng(n + 2, 9764, 9768, "period");
        // park unused timer
        // The host parks the timer at the slowest source while it is idle.
        wr(4'hE, 8'h03);
        ext_test = 1'b1;
        pre_stop = 1'b1;
        repeat (4) @(negedge clk);
        cmp8(8'(ck_oe), 8'h00, "pin is input");
        pre_stop = 1'b0;
        secs = 0;
        u_rct_partner.pulses(31);
        cmp_rng(secs, 0, 0, "before first");
        u_rct_partner.pulses(1);
        cmp_rng(secs, 1, 1, "first second");
        u_rct_partner.pulses(63);
        cmp_rng(secs, 1, 1, "before second");
        u_rct_partner.pulses(1);
        cmp_rng(secs, 2, 2, "second second");
        // The pin-fed 64 Hz and seconds ticks also serve as timer sources.
        wr(4'hF, 8'h03);
        wr(4'hE, 8'h81);
        u_rct_partner.pulses(2);
        rd_reg(4'hF);
        cmp8(rd, 8'h01, "64 Hz source");
        wr(4'hE, 8'h82);
        u_rct_partner.pulses(62);
        cmp_rng(secs, 3, 3, "third second");
        rd_reg(4'hF);
        cmp8(rd, 8'h03, "1 Hz source");
        ext_test = 1'b0;
        por_pending = 1'b1;
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        cmp8(8'(core_rst), 8'h01, "held at release");
        repeat (5) @(negedge clk);
        cmp8(8'(core_rst), 8'h01, "held");
        ovr_allow = 1'b1;
        u_rct_partner.ovr_walk();
        repeat (4) @(negedge clk);
        cmp8(8'(core_rst), 8'h00, "override");
        ovr_allow = 1'b0;
        repeat (4) @(negedge clk);
        cmp8(8'(core_rst), 8'h01, "override ended");
        u_rct_partner.ovr_walk();
        repeat (4) @(negedge clk);
        cmp8(8'(core_rst), 8'h01, "entry blocked");
        finish_test();
    end
endmodule : tb_rct_top
